// ==== hw/ieg_pkg.sv ====
package ieg_pkg;

  // Geometry
  localparam int NUM_LINES = 4;
  localparam int PRIO_W = 2;
  localparam int PORT_W = 8;
  localparam int VEC_W = 4;
  localparam int NUM_EV = 3;

  // Register byte offsets
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_SENSE = 6'h04;
  localparam logic [5:0] OFF_ENABLE = 6'h08;
  localparam logic [5:0] OFF_PEND = 6'h0C;
  localparam logic [5:0] OFF_PRIO = 6'h10;
  localparam logic [5:0] OFF_DIR = 6'h14;
  localparam logic [5:0] OFF_OPT = 6'h18;
  localparam logic [5:0] OFF_EVT = 6'h1C;
  localparam logic [5:0] OFF_EVMASK = 6'h20;
  localparam logic [5:0] OFF_STATUS = 6'h24;

  // Field positions
  localparam int CTRL_NEST = 0;
  localparam int EV_RESET_FETCH = 0;
  localparam int EV_UNWANTED = 1;
  localparam int EV_EDGE_LOST = 2;

  // Values after reset
  localparam logic [PORT_W-1:0] RST_DIR = 8'h00;
  localparam logic [PORT_W-1:0] RST_OPT = 8'h00;
  localparam logic RST_NEST = 1'b0;

  // Vector codes: line k is presented as k+1
  localparam logic [VEC_W-1:0] VEC_RESET = 4'h0;
  localparam logic [VEC_W-1:0] VEC_BASE = 4'h1;

  // One accepted register access
  typedef struct packed {
    logic any;
    logic wr;
    logic rd;
    logic [5:0] off;
    logic [31:0] wdat;
  } ieg_acc_t;

endpackage

// ==== hw/ieg_wb_port.sv ====
`timescale 1ns/1ps
module ieg_wb_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Register side
  input wire logic [31:0] rdata_i,
  output ieg_pkg::ieg_acc_t acc_o
);

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } ieg_wbp_state_t;

  ieg_wbp_state_t s;
  ieg_wbp_state_t next_s;
  logic accept;

  // One access per request; ack drops the cycle after it rose
  assign accept = wb_cyc_i && wb_stb_i && !s.ack;

  // Access strobe toward the register file
  always_comb
  begin
    acc_o.any = accept;
    acc_o.wr = accept && wb_we_i && wb_sel_i[0];
    acc_o.rd = accept && !wb_we_i;
    acc_o.off = {wb_adr_i[5:2], 2'b00};
    acc_o.wdat = wb_dat_i;
  end

  // Next state
  always_comb
  begin
    next_s = s;
    next_s.ack = accept;
    if (accept && !wb_we_i)
    begin
      next_s.dat = rdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.dat;

endmodule

// ==== hw/ieg_edge_guard.sv ====
`timescale 1ns/1ps
module ieg_edge_guard #(
  parameter int N = ieg_pkg::NUM_LINES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Lines and setup
  input wire logic [N-1:0] pin_i,
  input wire logic [N-1:0] sense_i,
  input wire logic blank_i,
  // Detected edges
  output logic [N-1:0] edge_o,
  output logic lost_o
);

  typedef struct packed {
    logic armed;
    logic [N-1:0] prev;
    logic [N-1:0] edg;
    logic lost;
  } ieg_eg_state_t;

  ieg_eg_state_t s;
  ieg_eg_state_t next_s;
  logic [N-1:0] raw;

  // Per line: sense 1 = rising, 0 = falling
  for (genvar g = 0; g < N; g++)
  begin : g_line
    assign raw[g] = s.armed &&
      (sense_i[g] ? (pin_i[g] && !s.prev[g]) : (!pin_i[g] && s.prev[g]));
  end

  // Blank window: history still moves on, so the edge is gone for good
  always_comb
  begin
    next_s = s;
    next_s.armed = 1'b1;
    next_s.prev = pin_i;
    next_s.edg = blank_i ? '0 : raw;
    next_s.lost = blank_i && (|raw);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign edge_o = s.edg;
  assign lost_o = s.lost;

endmodule

// ==== hw/ieg_entry_guard.sv ====
`timescale 1ns/1ps
// How it works
// - Request during flag restore yields reset vector
// - Direction/option access blanks edge detection one cycle
// - Mask bit set blocks all requests
// - Edge while clearing its flag gives unwanted reset
// - Clearing enable bit never gives that reset
// - Unnested: clear in any handler is safe
// - Nested: clear at equal/higher level is safe
module ieg_entry_guard #(
  parameter int N = ieg_pkg::NUM_LINES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // External interrupt lines
  input wire logic [N-1:0] ext_pin_i,
  // Port setup
  output logic [ieg_pkg::PORT_W-1:0] port_dir_o,
  output logic [ieg_pkg::PORT_W-1:0] port_opt_o,
  // CPU core side
  input wire logic cc_imask_i,
  input wire logic restore_cc_i,
  input wire logic cpu_ack_i,
  input wire logic cpu_interrupt_return_instruction_i,
  output logic irq_req_o,
  output logic [ieg_pkg::VEC_W-1:0] vector_o,
  output logic unwanted_reset_o,
  // Summary interrupt
  output logic irq_o
);

  localparam int PW = ieg_pkg::PRIO_W;
  localparam int IW = (N > 1) ? $clog2(N) : 1;

  typedef struct packed {
    logic nest;
    logic [N-1:0] sense;
    logic [N-1:0] enable;
    logic [N-1:0] pend;
    logic [N-1:0] active;
    logic [PW*N-1:0] prio;
    logic [ieg_pkg::PORT_W-1:0] dir;
    logic [ieg_pkg::PORT_W-1:0] opt;
    logic [ieg_pkg::NUM_EV-1:0] evt;
    logic [ieg_pkg::NUM_EV-1:0] evmask;
    logic req;
    logic [ieg_pkg::VEC_W-1:0] vec;
    logic ureset;
  } ieg_top_state_t;

  ieg_top_state_t s;
  ieg_top_state_t next_s;
  ieg_pkg::ieg_acc_t acc;
  logic [31:0] rdata;
  logic blank;
  logic [N-1:0] eg_edge;
  logic eg_lost;
  logic [N-1:0] pend_clr;
  logic [ieg_pkg::NUM_EV-1:0] evt_clr;
  logic [ieg_pkg::NUM_EV-1:0] ev_set;
  logic [IW+PW:0] pc;
  logic [IW+PW:0] pa;
  logic busy;
  logic [PW-1:0] cur_lvl;
  logic grant_ok;
  logic [N-1:0] nest_ok;
  logic [N-1:0] safe_vec;
  logic [N-1:0] hit;
  logic [ieg_pkg::VEC_W-1:0] ack_vec;

  // Highest level wins, lowest index breaks ties: {found, level, index}
  function automatic logic [IW+PW:0] pick(input logic [N-1:0] c,
                                          input logic [PW*N-1:0] p);
    logic [IW+PW:0] r;
    r = '0;
    for (int k = 0; k < N; k++)
    begin
      if (c[k] && (!r[IW+PW] || p[k*PW +: PW] > r[IW +: PW]))
      begin
        r = {1'b1, p[k*PW +: PW], IW'(k)};
      end
    end
    return r;
  endfunction

  // Bus front end
  ieg_wb_port u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .rdata_i(rdata),
    .acc_o(acc)
  );

  assign blank = acc.any &&
    (acc.off == ieg_pkg::OFF_DIR || acc.off == ieg_pkg::OFF_OPT);

  ieg_edge_guard #(.N(N)) u_eg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(ext_pin_i),
    .sense_i(s.sense),
    .blank_i(blank),
    .edge_o(eg_edge),
    .lost_o(eg_lost)
  );

  // Write-one-to-clear strobes
  assign pend_clr = (acc.wr && acc.off == ieg_pkg::OFF_PEND) ?
    acc.wdat[N-1:0] : '0;
  assign evt_clr = (acc.wr && acc.off == ieg_pkg::OFF_EVT) ?
    acc.wdat[ieg_pkg::NUM_EV-1:0] : '0;

  // Arbitration among enabled pending lines and running handlers
  assign pc = pick(s.pend & s.enable, s.prio);
  assign pa = pick(s.active, s.prio);
  assign busy = pa[IW+PW];
  assign cur_lvl = pa[IW +: PW];

  assign grant_ok = pc[IW+PW] && !cc_imask_i &&
    (!busy || (s.nest && pc[IW +: PW] > cur_lvl));

  // Lines whose level does not exceed the running handler
  for (genvar g = 0; g < N; g++)
  begin : g_safe
    assign nest_ok[g] = busy && (cur_lvl >= s.prio[g*PW +: PW]);
  end

  // Mask bracket also counts as safe
  assign safe_vec = ~s.enable | {N{cc_imask_i}} |
    (s.nest ? (s.active | nest_ok) : {N{busy}});

  // Edge meets its own flag clear
  assign hit = pend_clr & eg_edge & ~safe_vec;

  assign ev_set = {eg_lost, |hit, grant_ok && restore_cc_i};
  assign ack_vec = s.vec - ieg_pkg::VEC_BASE;

  // Register file, pending flags and handler tracking
  always_comb
  begin
    next_s = s;
    if (acc.wr)
    begin
      case (acc.off)
        ieg_pkg::OFF_CTRL: next_s.nest = acc.wdat[ieg_pkg::CTRL_NEST];
        ieg_pkg::OFF_SENSE: next_s.sense = acc.wdat[N-1:0];
        ieg_pkg::OFF_ENABLE: next_s.enable = acc.wdat[N-1:0];
        ieg_pkg::OFF_PRIO: next_s.prio = acc.wdat[PW*N-1:0];
        ieg_pkg::OFF_DIR: next_s.dir = acc.wdat[ieg_pkg::PORT_W-1:0];
        ieg_pkg::OFF_OPT: next_s.opt = acc.wdat[ieg_pkg::PORT_W-1:0];
        ieg_pkg::OFF_EVMASK:
          next_s.evmask = acc.wdat[ieg_pkg::NUM_EV-1:0];
        default: ;
      endcase
    end
    // Set beats clear so no edge is dropped
    next_s.pend = (s.pend & ~pend_clr) | eg_edge;
    next_s.evt = (s.evt & ~evt_clr) | ev_set;
    // Enable writes never reach the reset term
    next_s.ureset = |hit;
    next_s.req = grant_ok;
    // Restore in flight hides the source
    if (restore_cc_i)
    begin
      next_s.vec = ieg_pkg::VEC_RESET;
    end
    else
    begin
      next_s.vec = {{(ieg_pkg::VEC_W-IW){1'b0}}, pc[IW-1:0]} +
        ieg_pkg::VEC_BASE;
    end
    // Return retires the innermost (highest level) handler
    if (cpu_interrupt_return_instruction_i && busy)
    begin
      next_s.active[pa[IW-1:0]] = 1'b0;
    end
    // A reset-vector fetch enters no handler
    if (cpu_ack_i && s.req && s.vec != ieg_pkg::VEC_RESET)
    begin
      next_s.active[ack_vec[IW-1:0]] = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.nest <= ieg_pkg::RST_NEST;
      s.dir <= ieg_pkg::RST_DIR;
      s.opt <= ieg_pkg::RST_OPT;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    rdata = 32'h00000000;
    case (acc.off)
      ieg_pkg::OFF_CTRL: rdata = 32'(s.nest);
      ieg_pkg::OFF_SENSE: rdata = 32'(s.sense);
      ieg_pkg::OFF_ENABLE: rdata = 32'(s.enable);
      ieg_pkg::OFF_PEND: rdata = 32'(s.pend);
      ieg_pkg::OFF_PRIO: rdata = 32'(s.prio);
      ieg_pkg::OFF_DIR: rdata = 32'(s.dir);
      ieg_pkg::OFF_OPT: rdata = 32'(s.opt);
      ieg_pkg::OFF_EVT: rdata = 32'(s.evt);
      ieg_pkg::OFF_EVMASK: rdata = 32'(s.evmask);
      ieg_pkg::OFF_STATUS: rdata = 32'({busy, cur_lvl, s.active});
      default: rdata = 32'h00000000;
    endcase
  end

  // Outputs straight from state
  assign port_dir_o = s.dir;
  assign port_opt_o = s.opt;
  assign irq_req_o = s.req;
  assign vector_o = s.vec;
  assign unwanted_reset_o = s.ureset;
  assign irq_o = |(s.evt & s.evmask);

  // Checks

  sequence s_restore_hit;
    grant_ok && restore_cc_i;
  endsequence

  sequence s_reset_offer;
    irq_req_o && vector_o == ieg_pkg::VEC_RESET;
  endsequence

  property p_reset_vec;
    @(posedge clk_i) disable iff (rst_i)
    s_restore_hit |=> s_reset_offer ##0 s.evt[ieg_pkg::EV_RESET_FETCH];
  endproperty
  a_reset_vec: assert property (p_reset_vec)
    else $error("restore overlap did not give reset vector");

  property p_blank;
    @(posedge clk_i) disable iff (rst_i)
    blank |=> (eg_edge == '0) ##1 ((s.pend & ~$past(s.pend)) == '0);
  endproperty
  a_blank: assert property (p_blank)
    else $error("edge seen inside blank window");

  property p_gmask;
    @(posedge clk_i) disable iff (rst_i)
    cc_imask_i[*2] |=> !irq_req_o;
  endproperty
  a_gmask: assert property (p_gmask)
    else $error("request offered while mask bit set");

  property p_unwanted;
    @(posedge clk_i) disable iff (rst_i)
    (|hit) |=> unwanted_reset_o ##1 !unwanted_reset_o || $past(|hit);
  endproperty
  a_unwanted: assert property (p_unwanted)
    else $error("unsafe clear did not flag unwanted reset");

  property p_mask_clear;
    @(posedge clk_i) disable iff (rst_i)
    (acc.wr && acc.off == ieg_pkg::OFF_ENABLE) |=> !unwanted_reset_o;
  endproperty
  a_mask_clear: assert property (p_mask_clear)
    else $error("enable write raised unwanted reset");

  property p_nonest;
    @(posedge clk_i) disable iff (rst_i)
    (!s.nest && busy && pend_clr != '0) |=> !unwanted_reset_o;
  endproperty
  a_nonest: assert property (p_nonest)
    else $error("clear in handler raised reset");

  property p_nest;
    @(posedge clk_i) disable iff (rst_i)
    (s.nest && pend_clr != '0 && (pend_clr & ~nest_ok) == '0)
      |=> !unwanted_reset_o;
  endproperty
  a_nest: assert property (p_nest)
    else $error("nested safe clear raised reset");

  property p_set_wins;
    @(posedge clk_i) disable iff (rst_i)
    (eg_edge != '0) |=> ((s.pend & $past(eg_edge)) == $past(eg_edge));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("edge lost against flag clear");

  property p_irq_out;
    @(posedge clk_i) disable iff (rst_i)
    (unwanted_reset_o && s.evmask[ieg_pkg::EV_UNWANTED]) |-> irq_o;
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("masked-in event left irq low");

  sequence s_enter;
    cpu_ack_i && irq_req_o && vector_o != ieg_pkg::VEC_RESET &&
      !cpu_interrupt_return_instruction_i;
  endsequence

  property p_enter;
    @(posedge clk_i) disable iff (rst_i)
    s_enter |=> busy ##0 s.active[$past(ack_vec[IW-1:0])];
  endproperty
  a_enter: assert property (p_enter)
    else $error("taken vector did not mark handler active");

  property p_wb_ack;
    @(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("bus answer not one cycle after request");

endmodule

// ==== dv/ieg_cpu_model.sv ====
`timescale 1ns/1ps
module ieg_cpu_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench controls
  input wire logic auto_ack_i,
  input wire logic [3:0] ack_dly_i,
  input wire logic interrupt_return_instruction_cmd_i,
  // Controller side
  input wire logic irq_req_i,
  output logic cpu_ack_o,
  output logic cpu_interrupt_return_instruction_o
);
  logic [3:0] cnt;
  logic [1:0] hold;

  // Ack after a delay; hold off while the old offer still shows
  // Only offered requests taken
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt <= 4'h0;
      hold <= 2'h0;
      cpu_ack_o <= 1'h0;
    end
    else
    begin
      cpu_ack_o <= 1'h0;
      if (hold != 2'h0)
        hold <= hold - 2'h1;
      else if (irq_req_i && auto_ack_i)
      begin
        if (cnt >= ack_dly_i)
        begin
          cpu_ack_o <= 1'h1;
          cnt <= 4'h0;
          hold <= 2'h3;
        end
        else
          cnt <= cnt + 4'h1;
      end
      else
        cnt <= 4'h0;
    end
  end

  // Handler return, one cycle
  always_ff @(posedge clk_i)
    cpu_interrupt_return_instruction_o <= rst_i ? 1'h0 : interrupt_return_instruction_cmd_i;
endmodule

// ==== dv/ieg_entry_guard_tb.sv ====
`timescale 1ns/1ps
module ieg_entry_guard_tb;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc, stb, we, imask, restore, auto, iretc, cack, interrupt_return_instruction;
  logic [5:0] adr;
  logic [31:0] dat, rdat, rq;
  logic [3:0] pin, vec;
  logic ack, req, ur, irq;
  logic [7:0] dir, opt;
  int fail_count = 0;
  int check_count = 0;
  int ur_cnt = 0;

  ieg_entry_guard #(.N(4)) i_ieg_entry_guard (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_ack_o(ack), .wb_dat_o(rdat), .ext_pin_i(pin),
    .port_dir_o(dir), .port_opt_o(opt), .cc_imask_i(imask),
    .restore_cc_i(restore), .cpu_ack_i(cack), .cpu_interrupt_return_instruction_i(interrupt_return_instruction),
    .irq_req_o(req), .vector_o(vec), .unwanted_reset_o(ur),
    .irq_o(irq));

  ieg_cpu_model i_ieg_cpu_model (
    .clk_i(clk_i), .rst_i(rst_i), .auto_ack_i(auto),
    .ack_dly_i(4'h2), .interrupt_return_instruction_cmd_i(iretc), .irq_req_i(req),
    .cpu_ack_o(cack), .cpu_interrupt_return_instruction_o(interrupt_return_instruction));

  // Clock and pulse counter
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (ur === 1'h1)
      ur_cnt++;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      $display("ERROR t=%0t got %h expected %h", $time, g, e);
      fail_count++;
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Classic single cycle; pins change with the request
  task automatic wb(input logic w, input logic [5:0] a,
                    input logic [31:0] d, input logic [3:0] p);
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    pin <= p;
    @(posedge clk_i);
    // No answer time assumed; only the watchdog ends a hung wait
    while (ack !== 1'h1)
    begin
      @(posedge clk_i);
    end
    rq = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask

  task automatic w(input logic [5:0] a, input logic [31:0] d);
    wb(1'h1, a, d, pin);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    wb(1'h0, a, 32'h0, pin);
    chk(rq & m, e);
  endtask

  task automatic t_regs;
    rd(ieg_pkg::OFF_DIR, 32'hFF, 32'h0);
    rd(ieg_pkg::OFF_OPT, 32'hFF, 32'h0);
    rd(ieg_pkg::OFF_CTRL, 32'h1, 32'h0);
    rd(6'h3C, 32'hFFFFFFFF, 32'h0);
    w(ieg_pkg::OFF_OPT, 32'hC3);
    chk(32'(opt), 32'hC3);
    rd(ieg_pkg::OFF_OPT, 32'hFF, 32'hC3);
  endtask

  // Line 1: masked, reset vector during restore, then entry
  task automatic t_entry;
    w(ieg_pkg::OFF_ENABLE, 32'h2);
    wb(1'h1, ieg_pkg::OFF_CTRL, 32'h0, 4'hD);
    wt(6);
    chk(32'(req), 32'h0);
    rd(ieg_pkg::OFF_PEND, 32'hF, 32'h2);
    @(posedge clk_i);
    restore <= 1'h1;
    imask <= 1'h0;
    wt(4);
    chk(32'(req), 32'h1);
    chk(32'(vec), 32'(ieg_pkg::VEC_RESET));
    rd(ieg_pkg::OFF_EVT, 32'h1, 32'h1);
    @(posedge clk_i);
    restore <= 1'h0;
    wt(4);
    chk(32'(vec), 32'h2);
    auto <= 1'h1;
    wt(10);
    rd(ieg_pkg::OFF_STATUS, 32'h3F, 32'h02);
    auto <= 1'h0;
    imask <= 1'h1;
    iretc <= 1'h1;
    @(posedge clk_i);
    iretc <= 1'h0;
    rd(ieg_pkg::OFF_STATUS, 32'h3F, 32'h0);
    wb(1'h1, ieg_pkg::OFF_EVT, 32'h7, 4'hF);
    // Software masks before restoring flags
    @(posedge clk_i);
    restore <= 1'h1;
    wt(4);
    chk(32'(req), 32'h0);
    restore <= 1'h0;
    rd(ieg_pkg::OFF_EVT, 32'h1, 32'h0);
    w(ieg_pkg::OFF_PEND, 32'h2);
    w(ieg_pkg::OFF_ENABLE, 32'h0);
  endtask

  // Line 0 edge meets a DIR write, an OPT read, then a plain CTRL read;
  // software recovers the lost ones by semaphore and a replay call
  task automatic t_blank;
    logic sema;
    logic lvl;
    int replay;
    replay = 0;
    for (int i = 0; i < 3; i++)
    begin
      sema = 1'h1;
      lvl = pin[0];
      wb(i == 0, i == 0 ? ieg_pkg::OFF_DIR :
         (i == 1 ? ieg_pkg::OFF_OPT : ieg_pkg::OFF_CTRL), 32'h5A, 4'hE);
      wt(4);
      rd(ieg_pkg::OFF_PEND, 32'h1, i == 2);
      // A caught edge runs the handler, which drops the semaphore
      if (rq[0])
        sema = 1'h0;
      if (lvl && !pin[0] && sema)
      begin
        replay++;
        iretc <= 1'h1;
        @(posedge clk_i);
        iretc <= 1'h0;
        rd(ieg_pkg::OFF_STATUS, 32'h7F, 32'h0);
      end
      rd(ieg_pkg::OFF_EVT, 32'h4, i == 2 ? 32'h0 : 32'h4);
      wb(1'h1, ieg_pkg::OFF_EVT, 32'h4, 4'hF);
    end
    chk(32'(replay), 32'h2);
    chk(32'(dir), 32'h5A);
    w(ieg_pkg::OFF_PEND, 32'h1);
    // Rising sensitivity: fall ignored, rise caught
    w(ieg_pkg::OFF_SENSE, 32'h1);
    wb(1'h1, 6'h3C, 32'h0, 4'hE);
    wt(4);
    rd(ieg_pkg::OFF_PEND, 32'h1, 32'h0);
    wb(1'h1, 6'h3C, 32'h0, 4'hF);
    wt(4);
    rd(ieg_pkg::OFF_PEND, 32'h1, 32'h1);
    w(ieg_pkg::OFF_PEND, 32'h1);
    w(ieg_pkg::OFF_SENSE, 32'h0);
  endtask

  // Line 2 edge one cycle before the access lands
  task automatic ur_try(input logic [5:0] a, input logic [31:0] d,
                        input int e);
    int n0;
    n0 = ur_cnt;
    @(posedge clk_i);
    pin <= 4'hB;
    wb(1'h1, a, d, 4'hB);
    wt(3);
    chk(32'(ur_cnt - n0), 32'(e));
    wb(1'h1, 6'h3C, 32'hFF, 4'hF);
  endtask

  task automatic irqc(input logic e);
    wt(2);
    chk(32'(irq), 32'(e));
  endtask

  task automatic t_ur;
    w(ieg_pkg::OFF_PRIO, 32'hD0);
    w(ieg_pkg::OFF_ENABLE, 32'hC);
    w(ieg_pkg::OFF_EVMASK, 32'h2);
    imask <= 1'h0;
    ur_try(ieg_pkg::OFF_PEND, 32'h4, 1);
    rd(ieg_pkg::OFF_PEND, 32'h4, 32'h4);
    irqc(1'h1);
    w(ieg_pkg::OFF_EVMASK, 32'h0);
    irqc(1'h0);
    w(ieg_pkg::OFF_EVMASK, 32'h2);
    irqc(1'h1);
    w(ieg_pkg::OFF_EVT, 32'h2);
    irqc(1'h0);
    ur_try(ieg_pkg::OFF_ENABLE, 32'h8, 0);
    ur_try(ieg_pkg::OFF_PEND, 32'h4, 0);
    w(ieg_pkg::OFF_ENABLE, 32'hC);
    imask <= 1'h1;
    ur_try(ieg_pkg::OFF_PEND, 32'h4, 0);
    wb(1'h1, 6'h3C, 32'h0, 4'h7);
    wt(4);
    auto <= 1'h1;
    imask <= 1'h0;
    wt(10);
    auto <= 1'h0;
    rd(ieg_pkg::OFF_STATUS, 32'h3F, 32'h38);
    ur_try(ieg_pkg::OFF_PEND, 32'h4, 0);
    w(ieg_pkg::OFF_CTRL, 32'h1);
    ur_try(ieg_pkg::OFF_PEND, 32'h4, 0);
    // Nested entry above the running level; return pops the top one
    w(ieg_pkg::OFF_PRIO, 32'h70);
    auto <= 1'h1;
    wt(10);
    auto <= 1'h0;
    rd(ieg_pkg::OFF_STATUS, 32'h3F, 32'h3C);
    iretc <= 1'h1;
    @(posedge clk_i);
    iretc <= 1'h0;
    rd(ieg_pkg::OFF_STATUS, 32'h3F, 32'h18);
    imask <= 1'h1;
  endtask

  // Main sequence
  initial
  begin
    {cyc, stb, we, restore, auto, iretc} = 6'h0;
    imask = 1'h1;
    pin = 4'hF;
    adr = 6'h0;
    dat = 32'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    wt(2);
    t_regs;
    t_entry;
    t_blank;
    t_ur;
    end_sim;
  end

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    end_sim;
  end
endmodule
